// [bench/mhi_term_model.sv]
// behavioural terminal model driving the modem's control and data lines
`timescale 1ns/1ps
module mhi_term_model #(
   parameter int unsigned BIT_CYC = 3
) (
   // clock
   input wire logic sys_clk_i,
   // lines to the modem
   output mhi_pkg::mhi_term_ctl_s term_ctl_o,
   output logic term_txd_o
);
   initial begin
      term_ctl_o = '0;
      term_txd_o = 1'b1;
   end
   // ready rises once start-up is over and is never dropped again
   task automatic boot();
      @(negedge sys_clk_i);
      term_ctl_o.dtr = 1'b1;
   endtask
   task automatic req(input logic on);
      @(negedge sys_clk_i);
      term_ctl_o.rts = on;
   endtask
   // start bit, eight bits lsb first, stop bit; idle high afterwards
   task automatic send(input logic [7:0] w);
      logic [9:0] f;
      f = {1'b1, w, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(negedge sys_clk_i);
         term_txd_o = f[i];
         repeat (BIT_CYC - 1) @(negedge sys_clk_i);
      end
   endtask
endmodule

// [bench/tb_top.sv]
// self-checking testbench of the modem handshake indicators
`timescale 1ns/1ps
module tb_top;
   // short counts keep the run brief
   localparam int unsigned FL = 8;
   localparam int unsigned WM = 2;
   localparam int unsigned FT = 4;
   logic sys_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic term_rxd_i = 1'b1;
   logic rx_level_ok_i = 1'b0;
   logic term_txd_i;
   mhi_pkg::mhi_term_ctl_s term_ctl_i;
   logic cts_o;
   logic dcd_o;
   logic line_tx_en_o;
   mhi_pkg::mhi_leds_s leds_o;
   int bad_count = 0;
   int checks = 0;
   always #2.5 sys_clk_i = ~sys_clk_i;
   mhi_core #(.FLASH_CYC(FL), .WARM_CYC(WM), .FILT_CYC(FT)) i_dut (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .term_ctl_i(term_ctl_i),
      .term_txd_i(term_txd_i),
      .term_rxd_i(term_rxd_i),
      .cts_o(cts_o),
      .dcd_o(dcd_o),
      .rx_level_ok_i(rx_level_ok_i),
      .line_tx_en_o(line_tx_en_o),
      .leds_o(leds_o)
   );
   mhi_term_model i_term (
      .sys_clk_i(sys_clk_i),
      .term_ctl_o(term_ctl_i),
      .term_txd_o(term_txd_i)
   );
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask
   task automatic close_out();
      if (bad_count == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      tick(2);
      chk("cts", 1'b0, cts_o);
      chk("tx_en", 1'b0, line_tx_en_o);
      chk("dcd", 1'b0, dcd_o);
      chk("leds", 1'b0, |leds_o);
   endtask
   task automatic t_dtr();
      i_term.boot();
      tick(1);
      chk("led dtr", 1'b1, leds_o.dtr);
      chk("led rts", 1'b0, leds_o.rts);
   endtask
   task automatic t_rts();
      i_term.req(1'b1);
      tick(1);
      chk("tx_en", 1'b1, line_tx_en_o);
      chk("led rts", 1'b1, leds_o.rts);
      tick(WM - 1);
      chk("cts", 1'b0, cts_o);
      tick(1);
      chk("cts", 1'b1, cts_o);
      chk("led cts", 1'b1, leds_o.cts);
      tick(5);
      chk("led cts", 1'b1, leds_o.cts);
      i_term.req(1'b0);
      tick(1);
      chk("cts", 1'b0, cts_o);
      chk("tx_en", 1'b0, line_tx_en_o);
      chk("led cts", 1'b0, leds_o.cts);
      chk("led rts", 1'b0, leds_o.rts);
   endtask
   // request dropped inside the warm-up: clear must never come
   task automatic t_abort();
      i_term.req(1'b1);
      i_term.req(1'b0);
      for (int i = 0; i < WM + 3; i++) begin
         tick(1);
         chk("cts", 1'b0, cts_o);
      end
      chk("tx_en", 1'b0, line_tx_en_o);
   endtask
   task automatic t_txd();
      fork
         i_term.send(8'h55);
         begin
            // stretcher flop then panel flop: lamp shows two edges later
            tick(3);
            chk("led txd", 1'b1, leds_o.txd);
         end
      join
      chk("led rxd", 1'b0, leds_o.rxd);
      tick(FL - 3);
      chk("led txd", 1'b1, leds_o.txd);
      tick(5);
      chk("led txd", 1'b0, leds_o.txd);
   endtask
   task automatic t_rxd();
      term_rxd_i = 1'b0;
      tick(2);
      chk("led rxd", 1'b1, leds_o.rxd);
      term_rxd_i = 1'b1;
      tick(FL - 2);
      chk("led rxd", 1'b1, leds_o.rxd);
      tick(5);
      chk("led rxd", 1'b0, leds_o.rxd);
   endtask
   task automatic t_dcd();
      rx_level_ok_i = 1'b1;
      tick(FT);
      chk("dcd", 1'b0, dcd_o);
      tick(2);
      chk("dcd", 1'b1, dcd_o);
      chk("led dcd", 1'b1, leds_o.dcd);
      rx_level_ok_i = 1'b0;
      tick(1);
      chk("dcd", 1'b0, dcd_o);
      chk("led dcd", 1'b0, leds_o.dcd);
   endtask
   initial begin
      t_reset();
      tick(18);
      reset_i = 1'b0;
      t_reset();
      t_dtr();
      t_rts();
      t_abort();
      t_txd();
      t_rxd();
      t_dcd();
      close_out();
   end
   // whole run is about a hundred cycles
   initial begin
      #20000;
      bad_count++;
      close_out();
   end
endmodule

// [verilog/mhi_core.sv]
// module: control-line handshake and front-panel indicators of the modem
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Contract
// - The transmit indicator flashes with data words from the terminal.
// - The receive indicator flashes with data sent back to the terminal.
// - The terminal-ready indicator follows the terminal-ready input level.
// - The request indicator is lit while request-to-send is high, one cycle behind it.
// - On request the transmitter turns on and clear-to-send is then raised.
// - The clear indicator is lit for the whole time clear-to-send is high.
// - Dropping request turns the transmitter, clear and its indicator off.
// - Carrier detect is high once an adequate receive level has been present for FILT_CYC + 1 cycles, low without it.
// - Shared indicators show only request and clear states, no alternates.
module mhi_core #(
   parameter int unsigned FLASH_CYC = mhi_pkg::FLASH_MIN_CYC,
   parameter int unsigned WARM_CYC = mhi_pkg::TX_ON_CYC,
   parameter int unsigned FILT_CYC = mhi_pkg::DCD_FILT_CYC
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // terminal side
   input wire mhi_pkg::mhi_term_ctl_s term_ctl_i,
   input wire logic term_txd_i,
   input wire logic term_rxd_i,
   output logic cts_o,
   output logic dcd_o,
   // line side
   input wire logic rx_level_ok_i,
   output logic line_tx_en_o,
   // indicators
   output mhi_pkg::mhi_leds_s leds_o
);
   localparam int WCW = $clog2(WARM_CYC + 1);
   localparam logic [WCW-1:0] WARM_LD = WCW'(WARM_CYC);
   localparam int FCW = $clog2(FILT_CYC + 1);
   localparam logic [FCW-1:0] FILT_TOP = FCW'(FILT_CYC);

   ////////////////////////////////////////////////////////////////////////
   // data activity indicators
   logic led_txd, led_rxd;

   // stretch keeps a single short character visible
   mhi_stretch #(.HOLD_CYC(FLASH_CYC)) u_tx_act (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .line_i(term_txd_i),
      .led_o(led_txd)
   );

   mhi_stretch #(.HOLD_CYC(FLASH_CYC)) u_rx_act (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .line_i(term_rxd_i),
      .led_o(led_rxd)
   );

   ////////////////////////////////////////////////////////////////////////
   // transmitter sequencing and clear to send
   mhi_pkg::mhi_tx_state_e st_q, st_d;
   logic [WCW-1:0] warm_q, warm_d;
   logic cts_q, cts_d;
   logic tx_en_q, tx_en_d;

   // clear is only raised after the warm-up, so the terminal never sends
   // into a transmitter that is still settling
   always_comb begin
      st_d = st_q;
      warm_d = warm_q;
      case (st_q)
         mhi_pkg::MHI_TX_OFF: begin
            if (term_ctl_i.rts) begin
               st_d = mhi_pkg::MHI_TX_WARM;
               warm_d = WARM_LD;
            end
         end
         mhi_pkg::MHI_TX_WARM: begin
            if (!term_ctl_i.rts) begin
               st_d = mhi_pkg::MHI_TX_OFF;
            end else if (warm_q <= WCW'(1)) begin
               st_d = mhi_pkg::MHI_TX_ON;
            end else begin
               warm_d = warm_q - 1'b1;
            end
         end
         mhi_pkg::MHI_TX_ON: begin
            if (!term_ctl_i.rts) begin
               st_d = mhi_pkg::MHI_TX_OFF;
            end
         end
         default: begin
            st_d = mhi_pkg::MHI_TX_OFF;
         end
      endcase
      tx_en_d = (st_d != mhi_pkg::MHI_TX_OFF);
      cts_d = (st_d == mhi_pkg::MHI_TX_ON);
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         st_q <= mhi_pkg::MHI_TX_OFF;
         warm_q <= '0;
         cts_q <= mhi_pkg::RESET_CTS;
         tx_en_q <= 1'b0;
      end else begin
         st_q <= st_d;
         warm_q <= warm_d;
         cts_q <= cts_d;
         tx_en_q <= tx_en_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // carrier detect with a short filter against level chatter
   logic [FCW-1:0] filt_q, filt_d;
   logic dcd_q, dcd_d;

   always_comb begin
      filt_d = filt_q;
      dcd_d = dcd_q;
      if (rx_level_ok_i) begin
         if (filt_q != FILT_TOP) begin
            filt_d = filt_q + 1'b1;
         end else begin
            dcd_d = 1'b1;
         end
      end else begin
         filt_d = '0;
         dcd_d = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         filt_q <= '0;
         dcd_q <= 1'b0;
      end else begin
         filt_q <= filt_d;
         dcd_q <= dcd_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // panel; shared lamps carry only request and clear
   mhi_pkg::mhi_leds_s leds_q, leds_d;

   always_comb begin
      leds_d.txd = led_txd;
      leds_d.rxd = led_rxd;
      leds_d.dtr = term_ctl_i.dtr;
      leds_d.rts = term_ctl_i.rts;
      leds_d.cts = cts_d;
      leds_d.dcd = dcd_d;
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         leds_q <= '0;
      end else begin
         leds_q <= leds_d;
      end
   end

   assign leds_o = leds_q;
   assign cts_o = cts_q;
   assign dcd_o = dcd_q;
   assign line_tx_en_o = tx_en_q;

   ////////////////////////////////////////////////////////////////////////
   // assertions
   sequence s_rts_rise;
      !term_ctl_i.rts ##1 term_ctl_i.rts;
   endsequence

   a_dtr_led_follow: assert property (@(posedge sys_clk_i)
      disable iff (reset_i) ##1 leds_o.dtr == $past(term_ctl_i.dtr))
      else $error("dtr lamp does not follow input");

   a_rts_led_follow: assert property (@(posedge sys_clk_i)
      disable iff (reset_i) ##1 leds_o.rts == $past(term_ctl_i.rts))
      else $error("rts lamp does not follow input");

   a_cts_led_match: assert property (@(posedge sys_clk_i)
      disable iff (reset_i) leds_o.cts == cts_o)
      else $error("cts lamp differs from cts");

   a_cts_needs_tx: assert property (@(posedge sys_clk_i)
      disable iff (reset_i) cts_o |-> line_tx_en_o && leds_o.rts)
      else $error("cts without transmitter on");

   // a request dropped inside the warm-up aborts legally and ends the wait
   a_cts_after_rts: assert property (@(posedge sys_clk_i)
      disable iff (reset_i)
      s_rts_rise ##0 term_ctl_i.rts [*4] |->
         ##[0:40] (cts_o || !term_ctl_i.rts))
      else $error("cts not raised after rts");

   a_rts_drop_off: assert property (@(posedge sys_clk_i)
      disable iff (reset_i)
      $fell(term_ctl_i.rts) |=> !cts_o && !line_tx_en_o && !leds_o.cts)
      else $error("transmitter not released on rts drop");

   a_dcd_clear: assert property (@(posedge sys_clk_i)
      disable iff (reset_i) !rx_level_ok_i |=> !dcd_o)
      else $error("carrier kept without level");

   a_dcd_set: assert property (@(posedge sys_clk_i)
      disable iff (reset_i) rx_level_ok_i [*8] |=> dcd_o)
      else $error("carrier not detected");

   a_txd_flash: assert property (@(posedge sys_clk_i)
      disable iff (reset_i) $changed(term_txd_i) |-> ##[1:2] leds_o.txd)
      else $error("tx activity not shown");

   a_rxd_flash: assert property (@(posedge sys_clk_i)
      disable iff (reset_i)
      $changed(term_rxd_i) |-> ##[1:2] leds_o.rxd [*2])
      else $error("rx flash not stretched");

endmodule

// [verilog/mhi_pkg.sv]
// package: constants and carrier structs for the modem handshake indicators
package mhi_pkg;

   // clock rate and timing
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned CLK_PERIOD_PS = 5_000;
   // least visible flash of an activity indicator, in microseconds
   localparam int unsigned FLASH_MIN_US = 50_000;
   // scaled by cycles per microsecond so the product stays inside 32 bits
   localparam int unsigned FLASH_MIN_CYC =
      FLASH_MIN_US * (CLK_HZ / 1_000_000);
   // transmitter warm-up before clear to send, in nanoseconds
   localparam int unsigned TX_ON_NS = 100;
   localparam int unsigned TX_ON_CYC =
      (TX_ON_NS * 1_000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // carrier level filter length, in cycles
   localparam int unsigned DCD_FILT_CYC = 4;

   // reset values
   localparam logic RESET_LED = 1'b0;
   localparam logic RESET_CTS = 1'b0;
   localparam logic IDLE_LINE = 1'b1;

   // handshake lines from the terminal
   typedef struct packed {
      logic dtr;
      logic rts;
   } mhi_term_ctl_s;

   // front-panel indicators
   typedef struct packed {
      logic txd;
      logic rxd;
      logic dtr;
      logic rts;
      logic cts;
      logic dcd;
   } mhi_leds_s;

   // transmitter sequencing
   typedef enum logic [1:0] {
      MHI_TX_OFF,
      MHI_TX_WARM,
      MHI_TX_ON
   } mhi_tx_state_e;

endpackage

// [verilog/mhi_stretch.sv]
// module: activity pulse stretcher for one data indicator
`timescale 1ns/1ps
module mhi_stretch #(
   parameter int unsigned HOLD_CYC = mhi_pkg::FLASH_MIN_CYC
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // serial line sample
   input wire logic line_i,
   // indicator
   output logic led_o
);
   localparam int CW = $clog2(HOLD_CYC + 1);
   localparam logic [CW-1:0] HOLD_LD = CW'(HOLD_CYC);

   logic line_q, line_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic led_q, led_d;

   // any edge of the data line restarts the hold, so the flash tracks words
   always_comb begin
      line_d = line_i;
      cnt_d = cnt_q;
      if (line_i != line_q) begin
         cnt_d = HOLD_LD;
      end else if (cnt_q != '0) begin
         cnt_d = cnt_q - 1'b1;
      end
      led_d = (cnt_d != '0);
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         line_q <= mhi_pkg::IDLE_LINE;
         cnt_q <= '0;
         led_q <= mhi_pkg::RESET_LED;
      end else begin
         line_q <= line_d;
         cnt_q <= cnt_d;
         led_q <= led_d;
      end
   end

   assign led_o = led_q;

endmodule
